// *** verilog/dacs_pkg.sv ***
// constants for the dual converter channel select and status word block
package dacs_pkg;
	// register offsets on the plain port
	localparam logic [3:0] DACS_OFF_SELECT = 4'h0;
	localparam logic [3:0] DACS_OFF_CONFIG = 4'h1;
	localparam logic [3:0] DACS_OFF_STATUS = 4'h2;
	localparam logic [3:0] DACS_OFF_RESULT_A = 4'h3;
	localparam logic [3:0] DACS_OFF_RESULT_B = 4'h4;
	// field positions
	localparam int DACS_SEL_A_LSB = 0;
	localparam int DACS_SEL_B_LSB = 4;
	localparam int DACS_CFG_STATUS_BIT = 0;
	localparam int DACS_CFG_CRC_BIT = 1;
	localparam int DACS_ST_A_LSB = 12;
	localparam int DACS_ST_B_LSB = 8;
	// select codes
	localparam logic [3:0] DACS_CODE_SUPPLY = 4'h8;
	localparam logic [3:0] DACS_CODE_REGULATOR = 4'h9;
	localparam logic [3:0] DACS_CODE_SELFTEST = 4'hb;
	// self-test patterns
	localparam logic [15:0] DACS_PATTERN_A = 16'haaaa;
	localparam logic [15:0] DACS_PATTERN_B = 16'h5555;
	// reset values and crc polynomial
	localparam logic [7:0] DACS_SELECT_RST = 8'h00;
	localparam logic [1:0] DACS_CONFIG_RST = 2'h0;
	localparam logic [7:0] DACS_CRC_INIT = 8'h00;
	localparam logic [7:0] DACS_CRC_POLY = 8'h07;
	// output word stream states
	typedef enum logic [1:0] {DACS_IDLE, DACS_WORD_A, DACS_WORD_B, DACS_WORD_ST} dacs_state_t;
endpackage

// *** verilog/dacs_crc8.sv ***
// crc-8 accumulator over 16-bit result words
`timescale 1ns/10ps
`default_nettype none
module dacs_crc8 (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// control
	input wire logic i_clear,
	input wire logic i_word_valid,
	input wire logic [15:0] i_word,
	// running result
	output logic [7:0] o_crc
);
	logic [7:0] crc_reg;
	logic [7:0] crc_next;

	// msb-first crc over one word; bitwise so it needs no table
	always_comb begin
		crc_next = crc_reg;
		for (int i = 15; i >= 0; i--) begin
			if (crc_next[7] ^ i_word[i]) begin
				crc_next = {crc_next[6:0], 1'b0} ^ dacs_pkg::DACS_CRC_POLY;
			end else begin
				crc_next = {crc_next[6:0], 1'b0};
			end
		end
	end

	// accumulate, a clear starts a new frame
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || i_clear) begin
			crc_reg <= dacs_pkg::DACS_CRC_INIT;
		end else if (i_word_valid) begin
			crc_reg <= crc_next;
		end
	end

	assign o_crc = crc_reg;
endmodule
`default_nettype wire

// *** verilog/dacs_top.sv ***
// channel select decode, self-test substitution and status word output
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dacs_top (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// converter side
	input wire logic i_conv_done,
	input wire logic [15:0] i_conv_a_data,
	input wire logic [15:0] i_conv_b_data,
	output logic [3:0] o_conv_a_mux,
	output logic [3:0] o_conv_b_mux,
	output logic o_supply_mon_a,
	output logic o_supply_mon_b,
	output logic o_regulator_mon_a,
	output logic o_regulator_mon_b,
	output logic o_self_test,
	// result stream to host
	output logic o_out_valid,
	output logic [15:0] o_out_word,
	output logic o_out_is_status
);
	// this block sits between the sequencer layer that holds the two select codes
	// and the parallel readout path: it decides which input each converter sees
	// and what the host reads back for one frame
	// limitation: only one frame is held, a completion that arrives while a frame
	// streams is dropped, so conversions must be paced three or four cycles apart
	// limitation: reserved codes are not trapped; they route to input index zero
	// with no monitor raised, which keeps the decode small at the cost of letting
	// a careless host go unnoticed

	// software-visible selects and output enables
	logic [3:0] conv_a_input_select_reg; // code for converter A
	logic [3:0] conv_b_input_select_reg; // code for converter B
	logic status_word_output_enable_reg; // append status word
	logic checksum_output_enable_reg; // checksum enable; it only appends the status word, which carries the crc under either enable
	// frame capture
	logic [15:0] result_a_reg; // latched result of the current frame
	logic [15:0] result_b_reg;
	logic [3:0] frame_a_idx_reg; // channel indices captured at conversion
	logic [3:0] frame_b_idx_reg;
	logic [15:0] conversion_status_word_reg; // last emitted status, read only
	// stream sequencer and checksum path
	dacs_pkg::dacs_state_t state_reg; // which word leaves next
	logic self_test; // A select holds the self-test code
	logic [7:0] crc; // running checksum of the frame
	logic crc_valid; // a result word is leaving this cycle
	logic [15:0] crc_word; // the word fed into the checksum

	// both selects decode through one map
	// a code with the top bit set names a monitor, the test mode or a reserved code, never a pin
	function automatic logic [3:0] mux_of(input logic [3:0] code);
		mux_of = code[3] ? 4'h0 : code;
	endfunction

	// self-test is keyed on the A select alone; the B code then still drives the B routing outputs and the status index
	assign self_test = (conv_a_input_select_reg == dacs_pkg::DACS_CODE_SELFTEST);

	// software-writable select and config; status is not writable
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			conv_a_input_select_reg <= dacs_pkg::DACS_SELECT_RST[3:0];
			conv_b_input_select_reg <= dacs_pkg::DACS_SELECT_RST[7:4];
			status_word_output_enable_reg <= dacs_pkg::DACS_CONFIG_RST[0];
			checksum_output_enable_reg <= dacs_pkg::DACS_CONFIG_RST[1];
		end else if (i_wr) begin
			if (i_addr == dacs_pkg::DACS_OFF_SELECT) begin
				conv_a_input_select_reg <= i_wdata[dacs_pkg::DACS_SEL_A_LSB +: 4];
				conv_b_input_select_reg <= i_wdata[dacs_pkg::DACS_SEL_B_LSB +: 4];
			end else if (i_addr == dacs_pkg::DACS_OFF_CONFIG) begin
				status_word_output_enable_reg <= i_wdata[dacs_pkg::DACS_CFG_STATUS_BIT];
				checksum_output_enable_reg <= i_wdata[dacs_pkg::DACS_CFG_CRC_BIT];
			end
			// writes to the status offset are dropped
		end
	end

	// registered analog routing outputs
	// taken from flops so the analog switch controls never glitch while codes change
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_conv_a_mux <= 4'h0;
			o_conv_b_mux <= 4'h0;
			o_supply_mon_a <= 1'b0;
			o_supply_mon_b <= 1'b0;
			o_regulator_mon_a <= 1'b0;
			o_regulator_mon_b <= 1'b0;
			o_self_test <= 1'b0;
		end else begin
			// each flag is its own compare, so a monitor code raises exactly one per converter
			o_conv_a_mux <= mux_of(conv_a_input_select_reg);
			o_conv_b_mux <= mux_of(conv_b_input_select_reg);
			o_supply_mon_a <= conv_a_input_select_reg == dacs_pkg::DACS_CODE_SUPPLY;
			o_supply_mon_b <= conv_b_input_select_reg == dacs_pkg::DACS_CODE_SUPPLY;
			o_regulator_mon_a <= conv_a_input_select_reg == dacs_pkg::DACS_CODE_REGULATOR;
			o_regulator_mon_b <= conv_b_input_select_reg == dacs_pkg::DACS_CODE_REGULATOR;
			o_self_test <= self_test;
		end
	end

	// capture a frame; self-test swaps in the fixed patterns
	// codes are sampled at the completion edge, so a later write cannot alter this frame's indices
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			result_a_reg <= 16'h0000;
			result_b_reg <= 16'h0000;
			frame_a_idx_reg <= 4'h0;
			frame_b_idx_reg <= 4'h0;
		end else if (i_conv_done && state_reg == dacs_pkg::DACS_IDLE) begin
			result_a_reg <= self_test ? dacs_pkg::DACS_PATTERN_A : i_conv_a_data;
			result_b_reg <= self_test ? dacs_pkg::DACS_PATTERN_B : i_conv_b_data;
			frame_a_idx_reg <= conv_a_input_select_reg;
			frame_b_idx_reg <= conv_b_input_select_reg;
		end
	end

	// stream sequencer: A word, B word, then optional status word
	// a completion arriving mid-frame is ignored, the host must pace conversions
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_reg <= dacs_pkg::DACS_IDLE;
		end else begin
			unique case (state_reg)
				dacs_pkg::DACS_IDLE: begin
					// wait for a completion
					if (i_conv_done) begin
						state_reg <= dacs_pkg::DACS_WORD_A;
					end
				end
				dacs_pkg::DACS_WORD_A: begin
					// A always leaves first and B always follows
					state_reg <= dacs_pkg::DACS_WORD_B;
				end
				dacs_pkg::DACS_WORD_B: begin
					// either enable appends the status word
					if (status_word_output_enable_reg || checksum_output_enable_reg) begin
						state_reg <= dacs_pkg::DACS_WORD_ST;
					end else begin
						state_reg <= dacs_pkg::DACS_IDLE;
					end
				end
				dacs_pkg::DACS_WORD_ST: begin
					// last word of the frame
					state_reg <= dacs_pkg::DACS_IDLE;
				end
			endcase
		end
	end

	// crc runs over the words as they leave
	assign crc_valid = (state_reg == dacs_pkg::DACS_WORD_A) || (state_reg == dacs_pkg::DACS_WORD_B);
	assign crc_word = (state_reg == dacs_pkg::DACS_WORD_A) ? result_a_reg : result_b_reg;

	// the clear lands on the completion edge, one cycle before the A word enters
	dacs_crc8 u_crc (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_clear(i_conv_done && state_reg == dacs_pkg::DACS_IDLE),
		.i_word_valid(crc_valid),
		.i_word(crc_word),
		.o_crc(crc)
	);

	// status word, assembled in the status state, one cycle after the B word has entered the crc
	// the copy keeps the last emitted status; a frame with both enables off leaves it alone
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			conversion_status_word_reg <= 16'h0000;
		end else if (state_reg == dacs_pkg::DACS_WORD_ST) begin
			conversion_status_word_reg[dacs_pkg::DACS_ST_A_LSB +: 4] <= frame_a_idx_reg;
			conversion_status_word_reg[dacs_pkg::DACS_ST_B_LSB +: 4] <= frame_b_idx_reg;
			conversion_status_word_reg[7:0] <= crc;
		end
	end

	// output stream, registered
	// idle drives the word to zero so a stale result never lingers where the host looks
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_out_valid <= 1'b0;
			o_out_word <= 16'h0000;
			o_out_is_status <= 1'b0;
		end else begin
			// valid and the status flag follow the state one cycle late, like the word
			o_out_valid <= state_reg != dacs_pkg::DACS_IDLE;
			o_out_is_status <= state_reg == dacs_pkg::DACS_WORD_ST;
			unique case (state_reg)
				dacs_pkg::DACS_WORD_A: o_out_word <= result_a_reg;
				dacs_pkg::DACS_WORD_B: o_out_word <= result_b_reg;
				dacs_pkg::DACS_WORD_ST: o_out_word <= {frame_a_idx_reg, frame_b_idx_reg, crc};
				dacs_pkg::DACS_IDLE: o_out_word <= 16'h0000;
			endcase
		end
	end

	// read port, data one cycle after the strobe; unmapped reads give zero
	// zero outside the read slot lets the host combine several read ports with a plain or
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			unique case (i_addr)
				dacs_pkg::DACS_OFF_SELECT: o_rdata <= {8'h00, conv_b_input_select_reg, conv_a_input_select_reg};
				dacs_pkg::DACS_OFF_CONFIG: o_rdata <= {14'h0000, checksum_output_enable_reg,
					status_word_output_enable_reg};
				dacs_pkg::DACS_OFF_STATUS: o_rdata <= conversion_status_word_reg;
				dacs_pkg::DACS_OFF_RESULT_A: o_rdata <= result_a_reg;
				dacs_pkg::DACS_OFF_RESULT_B: o_rdata <= result_b_reg;
				default: o_rdata <= 16'h0000;
			endcase
		end else begin
			// outside the slot the data return to zero
			o_rdata <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// *** sim/dacs_top_sva.sv ***
// checker for the select decode, self-test words and status stream
`timescale 1ns/10ps
`default_nettype none
module dacs_top_sva (
	// watched ports
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_rd,
	input wire logic i_conv_done,
	input wire logic [15:0] o_rdata,
	input wire logic [3:0] o_conv_a_mux,
	input wire logic [3:0] o_conv_b_mux,
	input wire logic o_supply_mon_a,
	input wire logic o_supply_mon_b,
	input wire logic o_regulator_mon_a,
	input wire logic o_regulator_mon_b,
	input wire logic o_self_test,
	input wire logic o_out_valid,
	input wire logic [15:0] o_out_word,
	input wire logic o_out_is_status
);
	// one clock domain, so one default clock and reset
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	start_gap_a: assert property ($rose(o_out_valid) |-> $past(i_conv_done, 2))
		else $error("stream start late");
	pair_a: assert property ($rose(o_out_valid) |=> o_out_valid && !o_out_is_status)
		else $error("b word missing");
	tail_a: assert property (o_out_is_status |-> o_out_valid ##0 $past(o_out_valid, 2))
		else $error("status early");
	test_a_a: assert property ($rose(o_out_valid) && o_self_test |-> o_out_word == dacs_pkg::DACS_PATTERN_A)
		else $error("self-test a word wrong");
	test_b_a: assert property ($rose(o_out_valid) && o_self_test |=> o_out_word == dacs_pkg::DACS_PATTERN_B)
		else $error("self-test b word wrong");
	idx_a_a: assert property (o_out_is_status && o_self_test |-> o_out_word[15:12] == 4'hb)
		else $error("a index");
	// b index only provable from ports for analog codes above zero
	idx_b_a: assert property (o_out_is_status && o_conv_b_mux != 4'h0 |-> o_out_word[11:8] == o_conv_b_mux)
		else $error("b index wrong");
	mon_a: assert property (o_supply_mon_a |-> o_conv_a_mux == 4'h0 && !o_regulator_mon_a)
		else $error("monitor mux");
	idle_rd_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data outside slot");
endmodule
bind dacs_top dacs_top_sva chk_u (.i_ref_clk, .i_sys_rst, .i_rd, .i_conv_done, .o_rdata, .o_conv_a_mux, .o_conv_b_mux,
	.o_supply_mon_a, .o_supply_mon_b, .o_regulator_mon_a, .o_regulator_mon_b, .o_self_test, .o_out_valid,
	.o_out_word, .o_out_is_status);
`default_nettype wire

// *** sim/dacs_host_model.sv ***
// host that collects the result stream words of one frame
`timescale 1ns/10ps
`default_nettype none
module dacs_host_model (
	// clock and control
	input wire logic i_ref_clk,
	input wire logic i_clear,
	// stream from the device
	input wire logic i_valid,
	input wire logic i_is_status,
	input wire logic [15:0] i_word,
	// captured frame
	output logic [15:0] o_words [4],
	output logic [3:0] o_st_flags,
	output logic [2:0] o_count
);
	// capture in arrival order; stops at four so a runaway stream cannot wrap
	always_ff @(posedge i_ref_clk) begin
		if (i_clear) begin
			o_count <= 3'h0;
		end else if (i_valid && o_count < 3'h4) begin
			o_words[o_count[1:0]] <= i_word;
			o_st_flags[o_count[1:0]] <= i_is_status;
			o_count <= o_count + 3'h1;
		end
	end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// register and stream tests of the channel select and status block
`timescale 1ns/10ps
`default_nettype none
module tb;
	// design inputs and outputs
	logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_conv_done = 1'b0, h_clr = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0, i_conv_a_data = 16'h0, i_conv_b_data = 16'h0, o_rdata, o_out_word, q;
	logic [3:0] o_conv_a_mux, o_conv_b_mux, h_f;
	logic o_supply_mon_a, o_supply_mon_b, o_regulator_mon_a, o_regulator_mon_b, o_self_test, o_out_valid, o_out_is_status;
	logic [15:0] h_w [4];
	logic [2:0] h_n;
	int fail_count = 0, n_tests = 0, cycles = 0;
	dacs_top dut_u (.i_ref_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_conv_done, .i_conv_a_data,
		.i_conv_b_data, .o_conv_a_mux, .o_conv_b_mux, .o_supply_mon_a, .o_supply_mon_b, .o_regulator_mon_a,
		.o_regulator_mon_b, .o_self_test, .o_out_valid, .o_out_word, .o_out_is_status);
	dacs_host_model host_u (.i_ref_clk, .i_clear(h_clr), .i_valid(o_out_valid), .i_is_status(o_out_is_status),
		.i_word(o_out_word), .o_words(h_w), .o_st_flags(h_f), .o_count(h_n));
	// clock and hang guard; a run takes about 170 cycles
	always #12.5 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			stop_test;
		end
	end
	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one-cycle strobes, released on the following edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_ref_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
		@(posedge i_ref_clk) i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_ref_clk) {i_addr, i_rd} <= {a, 1'b1};
		@(posedge i_ref_clk) i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// crc-8, poly 07, init 0, msb first over a then b
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	// one conversion frame collected by the host model
	task automatic frame(input logic [7:0] sel, input logic [1:0] cfg, input logic [15:0] a, input logic [15:0] b);
		logic [15:0] ea, eb;
		ea = (sel[3:0] == 4'hb) ? 16'haaaa : a;
		eb = (sel[3:0] == 4'hb) ? 16'h5555 : b;
		wr(4'h1, {14'h0, cfg});
		wr(4'h0, {8'h0, sel});
		@(posedge i_ref_clk) h_clr <= 1'b0;
		@(posedge i_ref_clk) {i_conv_done, i_conv_a_data, i_conv_b_data} <= {1'b1, a, b};
		@(posedge i_ref_clk) i_conv_done <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
		#1 chk("count", {13'h0, h_n}, (cfg != 2'h0) ? 16'h3 : 16'h2);
		chk("word a", h_w[0], ea);
		chk("word b", h_w[1], eb);
		chk("self test", {15'h0, o_self_test}, {15'h0, sel[3:0] == 4'hb});
		if (cfg != 2'h0) begin
			chk("status", h_w[2], {sel[3:0], sel[7:4], crc8({ea, eb})});
			chk("flag", {15'h0, h_f[2]}, 16'h1);
			rd(4'h2, q);
			chk("status reg", q, {sel[3:0], sel[7:4], crc8({ea, eb})});
		end
		rd(4'h3, q);
		chk("result a", q, ea);
		rd(4'h4, q);
		chk("result b", q, eb);
		rd(4'h0, q);
		chk("select", q, {8'h0, sel});
		rd(4'h1, q);
		chk("config", q, {14'h0, cfg});
		@(posedge i_ref_clk) h_clr <= 1'b1;
	endtask
	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		rd(4'h2, q);
		chk("status reset", q, 16'h0);
		wr(4'h2, 16'hffff);
		rd(4'h2, q);
		chk("status write", q, 16'h0);
		rd(4'hf, q);
		chk("unmapped", q, 16'h0);
		// codes past 1001 are reserved or self-test, so the sweep stops there
		for (int c = 0; c < 10; c++) begin
			wr(4'h0, {8'h0, c[3:0], c[3:0]});
			repeat (3) @(posedge i_ref_clk);
			#1 chk("mux a", {12'h0, o_conv_a_mux}, (c < 8) ? {12'h0, c[3:0]} : 16'h0);
			chk("mux b", {12'h0, o_conv_b_mux}, (c < 8) ? {12'h0, c[3:0]} : 16'h0);
			chk("mons", {12'h0, o_supply_mon_a, o_supply_mon_b, o_regulator_mon_a, o_regulator_mon_b},
				(c == 8) ? 16'hc : (c == 9) ? 16'h3 : 16'h0);
		end
		frame(8'h25, 2'h1, 16'h1234, 16'habcd);
		frame(8'h2b, 2'h2, 16'h0f0f, 16'h00ff);
		frame(8'h71, 2'h3, 16'h8001, 16'h7ffe);
		frame(8'h71, 2'h0, 16'h4321, 16'h1357);
		stop_test;
	end
endmodule
`default_nettype wire
